/* hdl/dmiu_pkg.sv */
// dmiu_pkg: encodings, field positions, reset values and types of the data-move unit
// assumes 32-bit instruction words, 64-bit general registers and 64 register numbers
package dmiu_pkg;

   localparam int XLEN = 64;

   // opcode values, arbitrary implementation-defined choices
   localparam logic [7:0] conditional_move_opcode = 8'h20;
   localparam logic [7:0] constant_slice_opcode = 8'h21;
   localparam logic [7:0] address_reg_opcode = 8'h22;
   localparam logic [7:0] address_imm_opcode = 8'h23;
   localparam logic [7:0] special_read_opcode = 8'h24;
   localparam logic [7:0] special_write_opcode = 8'h25;

   // instruction field positions
   localparam int OPC_LSB = 24;
   localparam int SIZE_LSB = 22;
   localparam int NEG_BIT = 21;
   localparam int COND_LSB = 19;
   localparam int R3_LSB = 12;
   localparam int R2_LSB = 6;
   localparam int R1_LSB = 0;
   localparam int IMM_LSB = 6;
   localparam int SLICE_LSB = 22;
   localparam int DSEL_BIT = 23;
   localparam int SIGN_BIT = 22;

   // pipeline figures in cycles, and the pc step
   localparam int CMOVE_LAT = 2;
   localparam int SLICE_LAT = 1;
   localparam logic [63:0] PC_STEP = 64'h0000_0000_0000_0004;

   // special_register space
   localparam int SPR_COUNT = 16;
   localparam int SPR_IDX_W = 4;
   localparam logic [15:0] SPR_IMPL_MASK = 16'h7FFF;
   localparam logic [15:0] SPR_SUPER_MASK = 16'hF000;
   localparam logic [63:0] SPR_FMT_MASK = 64'hFFFF_0000_0000_0000;
   localparam logic [63:0] SPR_RESET = 64'h0000_0000_0000_0000;

   // control and status registers on the Avalon slave
   localparam logic [3:0] CSR_CTRL_ADDR = 4'h0;
   localparam logic [3:0] CSR_STATUS_ADDR = 4'h4;
   localparam logic [3:0] CSR_RETIRED_ADDR = 4'h8;
   localparam logic [31:0] CSR_CTRL_RESET = 32'h0000_0001;
   localparam int CTRL_SUPER_BIT = 0;
   localparam int CTRL_PREFETCH_BIT = 1;

   typedef enum logic [2:0] {
      EXC_NONE = 3'b000,
      EXC_BAD_COND = 3'b001,
      EXC_SPR_RIGHTS = 3'b010,
      EXC_SPR_INDEX = 3'b011,
      EXC_SPR_FORMAT = 3'b100
   } dmiu_exc_t;

   typedef enum logic [2:0] {
      SER_IDLE = 3'b000,
      SER_DRAIN = 3'b001,
      SER_ACCESS = 3'b010,
      SER_WAIT = 3'b011,
      SER_DONE = 3'b100
   } dmiu_ser_t;

endpackage : dmiu_pkg

/* hdl/dmiu_cond_merge.sv */
// dmiu_cond_merge: condition test and size-limited merge of a conditional move
// assumes operands arrive from the decode stage in the same cycle; purely combinational
`timescale 1ns/1ps
module dmiu_cond_merge
   import dmiu_pkg::*;
(
   input wire logic [63:0] cond_src_in,
   input wire logic neg_in,
   input wire logic [1:0] cond_sel_in,
   input wire logic [1:0] size_in,
   input wire logic [63:0] src_in,
   input wire logic [63:0] dst_in,
   output logic cond_true_out,
   output logic cond_valid_out,
   output logic [63:0] merged_out
);
   logic raw;
   logic [63:0] mask;

   always_comb begin
      raw = 1'b0;
      cond_valid_out = 1'b1;
      unique case (cond_sel_in)
         2'b00: raw = (cond_src_in == 64'h0000_0000_0000_0000);
         2'b01: cond_valid_out = 1'b0;
         2'b10: raw = cond_src_in[63];
         2'b11: raw = ~cond_src_in[0];
      endcase
      cond_true_out = (raw ^ neg_in) & cond_valid_out;
   end

   always_comb begin
      unique case (size_in)
         2'b00: mask = 64'h0000_0000_0000_00FF;
         2'b01: mask = 64'h0000_0000_0000_FFFF;
         2'b10: mask = 64'h0000_0000_FFFF_FFFF;
         2'b11: mask = 64'hFFFF_FFFF_FFFF_FFFF;
      endcase
      merged_out = (src_in & mask) | (dst_in & ~mask);
   end
endmodule : dmiu_cond_merge

/* hdl/dmiu_spr_bank.sv */
// dmiu_spr_bank: special_register storage with rights, index and format checks
// assumes one request pulse at a time; answer comes one cycle after the request
`timescale 1ns/1ps
module dmiu_spr_bank
   import dmiu_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic req_in,
   input wire logic write_in,
   input wire logic super_in,
   input wire logic [63:0] index_in,
   input wire logic [63:0] wdata_in,
   output logic done_out,
   output logic [63:0] rdata_out,
   output dmiu_exc_t exc_out
);
   logic [63:0] bank_reg [SPR_COUNT];
   logic [SPR_IDX_W-1:0] idx;
   dmiu_exc_t exc_next;

   assign idx = index_in[SPR_IDX_W-1:0];

   always_comb begin
      exc_next = EXC_NONE;
      if ((index_in[63:SPR_IDX_W] != '0) || !SPR_IMPL_MASK[idx]) begin
         exc_next = EXC_SPR_INDEX;
      end else if (SPR_SUPER_MASK[idx] && !super_in) begin
         exc_next = EXC_SPR_RIGHTS;
      end else if (write_in && ((wdata_in & SPR_FMT_MASK) != 64'h0000_0000_0000_0000)) begin
         exc_next = EXC_SPR_FORMAT;
      end
   end

   for (genvar i = 0; i < SPR_COUNT; i++) begin : g_entry
      always_ff @(posedge core_clk_in) begin
         if (sys_rst_in) begin
            bank_reg[i] <= SPR_RESET;
         end else if (req_in && write_in && exc_next == EXC_NONE && idx == SPR_IDX_W'(i)) begin
            bank_reg[i] <= wdata_in;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         done_out <= 1'b0;
         rdata_out <= 64'h0000_0000_0000_0000;
         exc_out <= EXC_NONE;
      end else begin
         done_out <= req_in;
         if (req_in) begin
            rdata_out <= (exc_next == EXC_NONE) ? bank_reg[idx] : 64'h0000_0000_0000_0000;
            exc_out <= exc_next;
         end
      end
   end
endmodule : dmiu_spr_bank

/* hdl/dmiu_core.sv */
// dmiu_core: decode and execute of conditional move, constant slice, address and spr access
// assumes decode holds instruction and operands stable while dec_ready_out is low
// How it works
// - conditional move copies source into destination only when the condition holds
// - condition looks at the whole condition register; size limits written part
// - destination register zero never receives a write
// - operand size comes from instruction bits 23-22
// - bit 21 negates; bits 20-19 pick zero, msb or lsb test
// - conditional move writes back two cycles after decode, one per cycle
// - constant slice puts the halfword at offset index times sixteen
// - constant slice never extends the halfword into other slices
// - slice index comes from bits 23-22, zero is the lowest slice
// - back-to-back constant slices flow without a stall via forwarding
// - constant slice writes back one cycle after decode, one per cycle
// - data-select flag set uses the data tlb, else the instruction tlb
// - tlb hit associates destination with load/store unit or fetcher
// - sign flag bit 22 sign-extends the halfword, else zero-extends
// - address and spr instructions ignore size and use full width
// - register address form takes two cycles and accepts one per cycle
// - spr read copies the whole indexed special register into destination
// - spr write copies the whole source into the indexed special register
// - spr access faults on rights, bad index, and on writes illegal format
// - spr accesses drain the pipeline and hold decode until done
//
// Implementation choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
module dmiu_core
   import dmiu_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic dec_valid_in,
   input wire logic [31:0] dec_instr_in,
   input wire logic [63:0] dec_pc_in,
   input wire logic [63:0] dec_op3_in,
   input wire logic [63:0] dec_op2_in,
   input wire logic [63:0] dec_op1_in,
   output logic dec_ready_out,
   output logic wb_fast_we_out,
   output logic [5:0] wb_fast_addr_out,
   output logic [63:0] wb_fast_data_out,
   output logic wb_slow_we_out,
   output logic [5:0] wb_slow_addr_out,
   output logic [63:0] wb_slow_data_out,
   output logic tlb_req_out,
   output logic tlb_data_sel_out,
   output logic [63:0] tlb_addr_out,
   input wire logic tlb_hit_in,
   output logic assoc_valid_out,
   output logic assoc_lsu_out,
   output logic [5:0] assoc_reg_out,
   output logic prefetch_out,
   output logic exc_valid_out,
   output logic [2:0] exc_cause_out,
   input wire logic [3:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out
);

   ////////////////////////////////////////////////////////////////////////////////
   // decode
   logic [7:0] opc;
   logic [5:0] r1;
   logic [15:0] imm;
   logic [1:0] slice;
   logic dsel;
   logic is_cm, is_lc, is_ar, is_ai, is_addr, is_get, is_put, is_spr;
   logic accept;
   dmiu_ser_t ser_state_reg;
   logic [31:0] ctrl_reg;

   assign opc = dec_instr_in[OPC_LSB +: 8];
   assign r1 = dec_instr_in[R1_LSB +: 6];
   assign imm = dec_instr_in[IMM_LSB +: 16];
   assign slice = dec_instr_in[SLICE_LSB +: 2];
   assign dsel = dec_instr_in[DSEL_BIT];
   assign is_cm = (opc == conditional_move_opcode);
   assign is_lc = (opc == constant_slice_opcode);
   assign is_ar = (opc == address_reg_opcode);
   assign is_ai = (opc == address_imm_opcode);
   assign is_get = (opc == special_read_opcode);
   assign is_put = (opc == special_write_opcode);
   assign is_addr = is_ar | is_ai;
   assign is_spr = is_get | is_put;

   // spr instructions are only taken once their access has finished
   assign dec_ready_out = ((ser_state_reg == SER_IDLE) && !is_spr)
                          || (ser_state_reg == SER_DONE);
   assign accept = dec_valid_in && dec_ready_out;

   ////////////////////////////////////////////////////////////////////////////////
   // destination forwarding so that dependent slices need no stall
   logic [63:0] old_dst;

   always_comb begin
      old_dst = dec_op1_in;
      if (wb_slow_we_out && wb_slow_addr_out == r1) begin
         old_dst = wb_slow_data_out;
      end
      if (wb_fast_we_out && wb_fast_addr_out == r1) begin
         old_dst = wb_fast_data_out;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // datapaths
   logic cm_cond_ok, cm_cond_valid;
   logic [63:0] cm_merged;
   logic [63:0] lc_res;
   logic [63:0] offset;
   logic [63:0] addr_sum;

   dmiu_cond_merge u_cond (
      .cond_src_in(dec_op3_in),
      .neg_in(dec_instr_in[NEG_BIT]),
      .cond_sel_in(dec_instr_in[COND_LSB +: 2]),
      .size_in(dec_instr_in[SIZE_LSB +: 2]),
      .src_in(dec_op2_in),
      .dst_in(old_dst),
      .cond_true_out(cm_cond_ok),
      .cond_valid_out(cm_cond_valid),
      .merged_out(cm_merged)
   );

   // halfword zero-filled then shifted, other slices come from old value
   assign lc_res = (old_dst & ~(64'h0000_0000_0000_FFFF << {slice, 4'h0}))
                   | ({48'h0000_0000_0000, imm} << {slice, 4'h0});

   always_comb begin
      if (is_ar) begin
         offset = dec_op2_in;
      end else if (dec_instr_in[SIGN_BIT]) begin
         offset = {{48{imm[15]}}, imm};
      end else begin
         offset = {48'h0000_0000_0000, imm};
      end
   end

   assign addr_sum = dec_pc_in + PC_STEP + offset;

   ////////////////////////////////////////////////////////////////////////////////
   // fast port: constant slice written one cycle after decode
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         wb_fast_we_out <= 1'b0;
         wb_fast_addr_out <= 6'h00;
         wb_fast_data_out <= 64'h0000_0000_0000_0000;
      end else begin
         wb_fast_we_out <= accept && is_lc && (r1 != 6'h00);
         if (accept && is_lc) begin
            wb_fast_addr_out <= r1;
            wb_fast_data_out <= lc_res;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // crossbar stage for conditional move and address generation
   logic s1_valid_reg, s1_addr_reg, s1_write_reg, s1_dsel_reg;
   logic [5:0] s1_rd_reg;
   logic [63:0] s1_data_reg;
   dmiu_exc_t s1_exc_reg;

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         s1_valid_reg <= 1'b0;
         s1_addr_reg <= 1'b0;
         s1_write_reg <= 1'b0;
         s1_dsel_reg <= 1'b0;
         s1_rd_reg <= 6'h00;
         s1_data_reg <= 64'h0000_0000_0000_0000;
         s1_exc_reg <= EXC_NONE;
      end else begin
         s1_valid_reg <= accept && (is_cm || is_addr);
         s1_addr_reg <= is_addr;
         s1_dsel_reg <= dsel;
         s1_rd_reg <= r1;
         s1_data_reg <= is_addr ? addr_sum : cm_merged;
         s1_write_reg <= (r1 != 6'h00) && (is_addr || (cm_cond_ok && cm_cond_valid));
         s1_exc_reg <= (is_cm && !cm_cond_valid) ? EXC_BAD_COND : EXC_NONE;
      end
   end

   assign tlb_req_out = s1_valid_reg && s1_addr_reg;
   assign tlb_data_sel_out = s1_dsel_reg;
   assign tlb_addr_out = s1_data_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // serialising spr access
   logic spr_done;
   logic [63:0] spr_rdata;
   dmiu_exc_t spr_exc;

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         ser_state_reg <= SER_IDLE;
      end else begin
         unique case (ser_state_reg)
            SER_IDLE: if (dec_valid_in && is_spr) ser_state_reg <= SER_DRAIN;
            SER_DRAIN: if (!s1_valid_reg) ser_state_reg <= SER_ACCESS;
            SER_ACCESS: ser_state_reg <= SER_WAIT;
            SER_WAIT: if (spr_done) ser_state_reg <= SER_DONE;
            SER_DONE: if (dec_valid_in) ser_state_reg <= SER_IDLE;
            default: ser_state_reg <= SER_IDLE;
         endcase
      end
   end

   dmiu_spr_bank u_spr (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .req_in(ser_state_reg == SER_ACCESS),
      .write_in(is_put),
      .super_in(ctrl_reg[CTRL_SUPER_BIT]),
      .index_in(dec_op2_in),
      .wdata_in(dec_op1_in),
      .done_out(spr_done),
      .rdata_out(spr_rdata),
      .exc_out(spr_exc)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // slow port, association and exceptions
   logic spr_take;
   assign spr_take = accept && (ser_state_reg == SER_DONE) && is_spr;

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         wb_slow_we_out <= 1'b0;
         wb_slow_addr_out <= 6'h00;
         wb_slow_data_out <= 64'h0000_0000_0000_0000;
      end else if (spr_take) begin
         wb_slow_we_out <= is_get && (spr_exc == EXC_NONE) && (r1 != 6'h00);
         wb_slow_addr_out <= r1;
         wb_slow_data_out <= spr_rdata;
      end else begin
         wb_slow_we_out <= s1_valid_reg && s1_write_reg;
         wb_slow_addr_out <= s1_rd_reg;
         wb_slow_data_out <= s1_data_reg;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         assoc_valid_out <= 1'b0;
         assoc_lsu_out <= 1'b0;
         assoc_reg_out <= 6'h00;
         prefetch_out <= 1'b0;
      end else begin
         assoc_valid_out <= tlb_req_out && tlb_hit_in && (s1_rd_reg != 6'h00);
         assoc_lsu_out <= s1_dsel_reg;
         assoc_reg_out <= s1_rd_reg;
         prefetch_out <= tlb_req_out && ctrl_reg[CTRL_PREFETCH_BIT];
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         exc_valid_out <= 1'b0;
         exc_cause_out <= EXC_NONE;
      end else if (spr_take) begin
         exc_valid_out <= (spr_exc != EXC_NONE);
         exc_cause_out <= spr_exc;
      end else begin
         exc_valid_out <= s1_valid_reg && (s1_exc_reg != EXC_NONE);
         exc_cause_out <= s1_valid_reg ? s1_exc_reg : EXC_NONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // avalon slave: control, status, retired count
   logic csr_ack_reg;
   logic csr_wr;
   logic [2:0] last_cause_reg;
   logic [7:0] exc_count_reg;
   logic [31:0] retired_reg;

   assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !csr_ack_reg;
   assign csr_wr = avs_write_in && csr_ack_reg;

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         csr_ack_reg <= 1'b0;
      end else begin
         csr_ack_reg <= (avs_read_in || avs_write_in) && !csr_ack_reg;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         ctrl_reg <= CSR_CTRL_RESET;
      end else if (csr_wr && avs_address_in == CSR_CTRL_ADDR && avs_byteenable_in[0]) begin
         ctrl_reg <= {30'h0000_0000, avs_writedata_in[1:0]};
      end
   end

   // a new exception in the clearing cycle wins over the clear
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         last_cause_reg <= 3'h0;
         exc_count_reg <= 8'h00;
      end else if (exc_valid_out) begin
         last_cause_reg <= exc_cause_out;
         exc_count_reg <= (csr_wr && avs_address_in == CSR_STATUS_ADDR) ? 8'h01
                          : exc_count_reg + 8'h01;
      end else if (csr_wr && avs_address_in == CSR_STATUS_ADDR) begin
         last_cause_reg <= 3'h0;
         exc_count_reg <= 8'h00;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         retired_reg <= 32'h0000_0000;
      end else if (accept) begin
         retired_reg <= retired_reg + 32'h0000_0001;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         avs_readdata_out <= 32'h0000_0000;
      end else if (avs_read_in && !csr_ack_reg) begin
         unique case (avs_address_in)
            CSR_CTRL_ADDR: avs_readdata_out <= ctrl_reg;
            CSR_STATUS_ADDR: avs_readdata_out <= {15'h0000, ser_state_reg != SER_IDLE,
                                                 exc_count_reg, 5'h00, last_cause_reg};
            CSR_RETIRED_ADDR: avs_readdata_out <= retired_reg;
            default: avs_readdata_out <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (sys_rst_in);

   sequence s_cmove_take;
      accept && is_cm && cm_cond_ok && (r1 != 6'h00);
   endsequence

   sequence s_slice_take;
      accept && is_lc && (r1 != 6'h00);
   endsequence

   chk_cmove_latency: assert property (s_cmove_take |-> ##2 (wb_slow_we_out
         && wb_slow_addr_out == $past(r1, 2)))
      else $error("conditional move not written two cycles after decode");

   chk_cmove_merge: assert property (s_cmove_take |-> ##2
         (wb_slow_data_out == $past(cm_merged, 2)))
      else $error("conditional move data not size merged");

   chk_zero_silent: assert property (!(wb_slow_we_out && wb_slow_addr_out == 6'h00)
         && !(wb_fast_we_out && wb_fast_addr_out == 6'h00))
      else $error("register zero written");

   chk_bad_cond: assert property (accept && is_cm && !cm_cond_valid |-> ##2
         (exc_valid_out && exc_cause_out == EXC_BAD_COND && !wb_slow_we_out))
      else $error("unassigned condition not faulted");

   chk_slice_latency: assert property (s_slice_take |-> ##1
         (wb_fast_we_out && wb_fast_data_out == $past(lc_res)))
      else $error("constant slice not written one cycle after decode");

   chk_slice_place: assert property (wb_fast_we_out |->
         ((wb_fast_data_out >> {$past(slice), 4'h0}) & 64'h0000_0000_0000_FFFF)
         == {48'h0000_0000_0000, $past(imm)})
      else $error("halfword not at selected slice");

   chk_slice_flow: assert property (dec_valid_in && is_lc && ser_state_reg == SER_IDLE
         |-> dec_ready_out)
      else $error("constant slice stalled");

   chk_addr_sum: assert property (accept && is_addr && (r1 != 6'h00) |-> ##2
         (wb_slow_we_out && wb_slow_data_out == $past(addr_sum, 2)))
      else $error("address result wrong or late");

   chk_tlb_select: assert property (accept && is_addr |-> ##1
         (tlb_req_out && tlb_data_sel_out == $past(dsel)))
      else $error("wrong tlb selected");

   chk_serial_hold: assert property ((ser_state_reg != SER_IDLE)
         && (ser_state_reg != SER_DONE) |-> !dec_ready_out)
      else $error("decode not held during spr access");

   chk_serial_bound: assert property (ser_state_reg == SER_DRAIN |-> ##[1:4]
         (ser_state_reg == SER_DONE))
      else $error("spr access did not finish in time");

endmodule : dmiu_core

/* test/dmiu_tlb_model.sv */
// dmiu_tlb_model: far-side tlb answering the address checks of dmiu_core
// assumes addresses with bit 63 clear are mapped, all others miss
`timescale 1ns/1ps
module dmiu_tlb_model (
   input wire logic core_clk_in,
   input wire logic tlb_req_in,
   input wire logic [63:0] tlb_addr_in,
   output logic tlb_hit_out
);
   logic junk_reg = 1'b0;
   always_ff @(posedge core_clk_in) begin
      junk_reg <= !junk_reg;
   end
   // answer only while a check is requested, else a changing pattern
   assign tlb_hit_out = tlb_req_in ? !tlb_addr_in[63] : junk_reg;
endmodule : dmiu_tlb_model

/* test/data_move_instruction_unit_tb_top.sv */
// data_move_instruction_unit_tb_top: self-checking bench of dmiu_core
// assumes dmiu_tlb_model on the tlb side and a 200 MHz core clock
`timescale 1ns/1ps
module data_move_instruction_unit_tb_top import dmiu_pkg::*;;
   logic clk, rst, valid, av_rd, av_wr, rdy0, dec_ready, fwe, swe, treq, tsel, hit;
   logic asv, asl, pf, exv, wrq;
   logic [31:0] instr, av_wd, rd, avrd;
   logic [63:0] pc, op3, op2, op1, ex, fd, sd, ta;
   logic [63:0] kx = 64'hFEDC_BA98_7654_3210;
   logic [7:0] wt = 8'h1C;
   logic [5:0] fa, sa, ar;
   logic [3:0] av_a;
   logic [2:0] exc;
   int errors, n_checks;
   dmiu_core DUT (.core_clk_in(clk), .sys_rst_in(rst), .dec_valid_in(valid),
      .dec_instr_in(instr), .dec_pc_in(pc), .dec_op3_in(op3), .dec_op2_in(op2),
      .dec_op1_in(op1), .dec_ready_out(dec_ready), .wb_fast_we_out(fwe),
      .wb_fast_addr_out(fa), .wb_fast_data_out(fd), .wb_slow_we_out(swe),
      .wb_slow_addr_out(sa), .wb_slow_data_out(sd), .tlb_req_out(treq),
      .tlb_data_sel_out(tsel), .tlb_addr_out(ta), .tlb_hit_in(hit),
      .assoc_valid_out(asv), .assoc_lsu_out(asl), .assoc_reg_out(ar), .prefetch_out(pf),
      .exc_valid_out(exv), .exc_cause_out(exc), .avs_address_in(av_a), .avs_read_in(av_rd),
      .avs_write_in(av_wr), .avs_writedata_in(av_wd), .avs_byteenable_in(4'hF),
      .avs_readdata_out(avrd), .avs_waitrequest_out(wrq));
   dmiu_tlb_model TLB (.core_clk_in(clk), .tlb_req_in(treq), .tlb_addr_in(ta),
      .tlb_hit_out(hit));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = !clk;
   end
   ////////////////////////////////////////////////////////////
   task chk(input logic [63:0] s, e);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task test_done;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done
   // issue one instruction, wait until taken, then n more edges
   task go(input logic [31:0] i, input logic [63:0] a3, a2, a1, input int n);
      @(posedge clk);
      valid <= 1'b1;
      instr <= i;
      {op3, op2, op1} <= {a3, a2, a1};
      @(posedge clk);
      rdy0 = dec_ready;
      while (dec_ready !== 1'b1) begin
         @(posedge clk);
      end
      valid <= 1'b0;
      repeat (n) @(posedge clk);
      #1;
   endtask : go
   task av(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      av_rd <= !w;
      av_wr <= w;
      av_a <= a;
      av_wd <= d;
      @(posedge clk);
      while (wrq !== 1'b0) begin
         @(posedge clk);
      end
      rd = avrd;
      av_rd <= 1'b0;
      av_wr <= 1'b0;
   endtask : av
   task adr(input logic [31:0] i, input logic [63:0] a2, e, input logic ds, h);
      go(i, 0, a2, 0, 0);
      chk(treq, 1);
      chk(tsel, ds);
      chk(ta, e);
      @(posedge clk);
      #1;
      chk(sd, e);
      chk(asv, h);
      chk(pf, 1);
      if (h) chk(asl, ds);
   endtask : adr
   task spr(input logic [31:0] i, input logic [63:0] a2, a1, input logic [2:0] c);
      go(i, 0, a2, a1, 0);
      chk(rdy0, 0);
      chk(exv, c != 0);
      if (c != 0) chk(exc, c);
   endtask : spr
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (3000) @(posedge clk);
      errors++;
      test_done;
   end
   initial begin
      {rst, valid, av_rd, av_wr, av_a, av_wd, instr} = {3'b100, 1'b0, 4'h0, 64'h0};
      {op3, op2, op1} = 0;
      pc = 64'h1000;
      errors = 0;
      n_checks = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      for (int c = 0; c < 8; c++) begin
         go({conditional_move_opcode, 2'b00, c[2:0], 1'b0, 6'd3, 6'd2, 6'd5},
            64'h8000_0000_0000_0000, kx, 64'h0123_4567_89AB_CDEF, 1);
         chk(swe, wt[c]);
         if (wt[c]) chk(sd, 64'h0123_4567_89AB_CD10);
         chk(exv, c == 1 || c == 5);
      end
      go({conditional_move_opcode, 6'b10_1000, 6'd3, 6'd2, 6'd5}, 1, kx, 64'h0123_4567_89AB_CDEF, 1);
      chk(sd, 64'h0123_4567_7654_3210);
      go({conditional_move_opcode, 6'b11_1000, 6'd3, 6'd2, 6'd0}, 1, kx, 0, 1);
      chk(swe, 0);
      ex = 64'h0124_3567_89AB_CDEF;
      for (int k = 0; k < 5; k++) begin
         @(posedge clk);
         valid <= (k < 4);
         instr <= {constant_slice_opcode, k[1:0], kx[k[1:0] * 16 +: 16], 6'd7};
         op1 <= 64'h0124_3567_89AB_CDEF;
         if (k > 0) begin
            #1;
            ex[(k - 1) * 16 +: 16] = kx[(k - 1) * 16 +: 16];
            chk(fwe, 1);
            chk(fd, ex);
         end
      end
      spr({special_write_opcode, 12'h0, 6'd2, 6'd4}, 3, 64'h0000_1234_5678_9ABC, 0);
      spr({special_read_opcode, 12'h0, 6'd2, 6'd11}, 3, 0, 0);
      chk(sd, 64'h0000_1234_5678_9ABC);
      spr({special_write_opcode, 12'h0, 6'd2, 6'd4}, 15, 0, 3);
      spr({special_write_opcode, 12'h0, 6'd2, 6'd4}, 4, 64'hFFFF_0000_0000_0000, 4);
      av(0, 4'h0, 0);
      chk(rd, 32'h1);
      av(0, 4'hC, 0);
      chk(rd, 0);
      av(1, 4'h0, 32'h2);
      av(0, 4'h0, 0);
      chk(rd, 32'h2);
      av(0, 4'h4, 0);
      chk(rd, 32'h0000_0404);
      spr({special_write_opcode, 12'h0, 6'd2, 6'd4}, 12, 0, 2);
      adr({address_reg_opcode, 12'h800, 6'd2, 6'd9}, 64'hFFFF_FFFF_FFFF_FFF0, 64'hFF4, 1, 1);
      adr({address_imm_opcode, 2'b01, 16'h8000, 6'd9}, 0, 64'hFFFF_FFFF_FFFF_9004, 0, 0);
      adr({address_imm_opcode, 2'b10, 16'h8000, 6'd9}, 0, 64'h9004, 1, 1);
      test_done;
   end
endmodule : data_move_instruction_unit_tb_top
